// *** ipg_interrupt_pulse_generator.sv ***
/*
  Active-low interrupt pulse generator with status latching, group masks,
  wake-source gating, minimum gap, periodic reminders and Init-mode pin
  sensing. Assumes the mode controller and event sources are synchronous
  to i_clock and that the register port master follows plain strobes.
*/
// Behaviour
// - in Normal or Stop a pulse holds the pin low for 100 us
// - the pin stays high at least 100 us between pulses
// - a pulse never changes the operating mode
// - a mask register enables each status group separately
// - groups are ORs of status bits minus the excluded fault bits
// - wake events interrupt only when their source is enabled, except Init exit with the wake pin high and Stop entry with wake bits set
// - mask groups and wake events trigger pulses independently
// - reset flag and supply or thermal shutdown faults never pulse
// - uncleared serial failure status repeats pulses every 5 ms
// - reminders come only from frame or checksum failure bits
// - clearing periodic enable stops reminder pulses
// - no pulses in Restart, Fail-Safe or Sleep
// - entering Stop with wake or brake bits set fires a pulse
// - readable status views refresh at each pulse falling edge
// - events stay latched until software clears them
// - simultaneous events while low give one single pulse
// - in Init the filtered pin level selects debug bring-up mode
// - wake pin edges interrupt in Normal/Stop, wake in Sleep/Fail-Safe
// - Init to Normal with wake pin high sets wake status and pulses
`timescale 1ns/1ns
module ipg_interrupt_pulse_generator
  import ipg_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES  = IPG_PULSE_CYC,
  parameter int unsigned GAP_CYCLES    = IPG_GAP_CYC,
  parameter int unsigned REMIND_CYCLES = IPG_REMIND_CYC,
  parameter int unsigned FILT_CYCLES   = IPG_FILT_CYC
) (
  input  logic              i_clock,
  input  logic              i_rst_b,
  input  ipg_mode_e         i_mode,
  input  logic [7:0]        i_supply_evt,
  input  logic [7:0]        i_thermal_evt,
  input  logic [7:0]        i_drain_evt,
  input  logic [7:0]        i_device_evt,
  input  logic              i_wake_edge,
  input  logic              i_wake_level,
  input  logic              i_timer_wake,
  input  logic              i_intn_pin,
  input  logic [IPG_AW-1:0] i_addr,
  input  logic [IPG_DW-1:0] i_wdata,
  input  logic              i_wr,
  input  logic              i_rd,
  output logic [IPG_DW-1:0] o_rdata,
  output logic              o_intn_out,
  output logic              o_intn_oe_n,
  output logic              o_debug_bringup,
  output logic              o_wake_request
);

  ipg_mode_e  mode_q;
  ipg_mode_e  mode_prev;
  ipg_state_e state;
  logic [7:0] interrupt_mask_reg;
  logic [7:0] cfg_reg;
  logic [7:0] supply_status_reg;
  logic [7:0] thermal_status_reg;
  logic [7:0] drain_source_overvoltage_reg;
  logic [7:0] device_status_reg;
  logic [7:0] wake_status_reg;
  logic [7:0] supply_view;
  logic [7:0] thermal_view;
  logic [7:0] drain_view;
  logic [7:0] device_view;
  logic [7:0] wake_view;
  logic [3:0] grp;
  logic [3:0] grp_q;
  logic [2:0] wake_q;
  logic [3:0] grp_new;
  logic [2:0] wake_new;
  logic [7:0] sup_clr;
  logic [7:0] therm_clr;
  logic [7:0] drain_clr;
  logic [7:0] dev_clr;
  logic [7:0] wake_clr;
  logic [7:0] wake_set;
  logic       mode_ok;
  logic       stop_entry;
  logic       init_exit_wake;
  logic       trig;
  logic       pend;
  logic       start;
  logic       tmr_ld;
  logic       tmr_done;
  logic       rem_cond;
  logic       rem_done;
  logic       rem_trig;
  logic       filt_ld;
  logic       filt_done;

  // mode is only observed; nothing here feeds back into it
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      mode_q    <= IPG_INIT;
      mode_prev <= IPG_INIT;
    end else begin
      mode_q    <= i_mode;
      mode_prev <= mode_q;
    end
  end

  assign mode_ok        = ipg_irq_mode_ok(mode_q);
  assign stop_entry     = (mode_q == IPG_STOP) && (mode_prev != IPG_STOP);
  assign init_exit_wake = (mode_prev == IPG_INIT) &&
                          (mode_q == IPG_NORMAL) && i_wake_level;

  // write-one-to-clear strobes per status register
  assign sup_clr   = (i_wr && i_addr == IPG_OFS_SUP)   ? i_wdata : 8'h00;
  assign therm_clr = (i_wr && i_addr == IPG_OFS_THERM) ? i_wdata : 8'h00;
  assign drain_clr = (i_wr && i_addr == IPG_OFS_DRAIN) ? i_wdata : 8'h00;
  assign dev_clr   = (i_wr && i_addr == IPG_OFS_DEV)   ? i_wdata : 8'h00;
  assign wake_clr  = (i_wr && i_addr == IPG_OFS_WAKE)  ? i_wdata : 8'h00;

  // wake status sources; brake only when braking is enabled
  always_comb begin
    wake_set                 = 8'h00;
    wake_set[IPG_WAKE_PIN]   = i_wake_edge | init_exit_wake;
    wake_set[IPG_WAKE_TIMER] = i_timer_wake;
    wake_set[IPG_WAKE_BRAKE] = cfg_reg[IPG_CFG_BRAKE] &
                               (|(i_drain_evt & IPG_BRAKE_BITS));
  end

  // control registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      interrupt_mask_reg <= IPG_MASK_RST;
      cfg_reg            <= IPG_CFG_RST;
    end else if (i_wr) begin
      if (i_addr == IPG_OFS_MASK) begin
        interrupt_mask_reg <= i_wdata;
      end
      if (i_addr == IPG_OFS_CFG) begin
        cfg_reg <= i_wdata;
      end
    end
  end

  // latched events; a new event beats a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      supply_status_reg            <= 8'h00;
      thermal_status_reg           <= 8'h00;
      drain_source_overvoltage_reg <= 8'h00;
      device_status_reg            <= 8'h00;
      wake_status_reg              <= 8'h00;
    end else begin
      supply_status_reg  <= (supply_status_reg & ~sup_clr) |
                            i_supply_evt;
      thermal_status_reg <= (thermal_status_reg & ~therm_clr) |
                            i_thermal_evt;
      drain_source_overvoltage_reg <=
        (drain_source_overvoltage_reg & ~drain_clr) | i_drain_evt;
      device_status_reg  <= (device_status_reg & ~dev_clr) |
                            i_device_evt;
      wake_status_reg    <= ((wake_status_reg & ~wake_clr) | wake_set) &
                            IPG_WAKE_SRC;
    end
  end

  // readable views: snapshot at falling edge, clears still apply
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      supply_view  <= 8'h00;
      thermal_view <= 8'h00;
      drain_view   <= 8'h00;
      device_view  <= 8'h00;
      wake_view    <= 8'h00;
    end else if (start) begin
      supply_view  <= supply_status_reg;
      thermal_view <= thermal_status_reg;
      drain_view   <= drain_source_overvoltage_reg;
      device_view  <= device_status_reg;
      wake_view    <= wake_status_reg;
    end else begin
      supply_view  <= supply_view & ~sup_clr;
      thermal_view <= thermal_view & ~therm_clr;
      drain_view   <= drain_view & ~drain_clr;
      device_view  <= device_view & ~dev_clr;
      wake_view    <= wake_view & ~wake_clr;
    end
  end

  // group flags without the faults handled by restart or fail-safe
  always_comb begin
    grp                  = 4'h0;
    grp[IPG_GRP_SUPPLY]  = |(supply_status_reg & ~IPG_SUP_NOINT);
    grp[IPG_GRP_THERMAL] = |(thermal_status_reg & ~IPG_THERM_NOINT);
    grp[IPG_GRP_BRIDGE]  = |drain_source_overvoltage_reg;
    grp[IPG_GRP_SERIAL]  = |(device_status_reg & IPG_DEV_SERIAL);
  end

  // previous flags for rising-edge detection
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      grp_q  <= 4'h0;
      wake_q <= 3'h0;
    end else begin
      grp_q  <= grp;
      wake_q <= wake_status_reg[2:0];
    end
  end

  assign grp_new  = grp & ~grp_q & interrupt_mask_reg[3:0];
  assign wake_new = wake_status_reg[2:0] & ~wake_q & cfg_reg[2:0];

  // both methods feed one trigger
  assign trig = mode_ok & ((|grp_new) | (|wake_new) | rem_trig |
                init_exit_wake |
                (stop_entry & ((|wake_status_reg) |
                 (|(drain_source_overvoltage_reg & IPG_BRAKE_BITS)))));

  // reminder timing while serial failure bits stay set
  assign rem_cond = cfg_reg[IPG_CFG_CYC] &
                    interrupt_mask_reg[IPG_GRP_SERIAL] &
                    (|(device_status_reg & IPG_DEV_SERIAL));
  assign rem_trig = rem_cond & rem_done;

  ipg_timer #(.W(IPG_RW)) u_remind (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_load  (start | ~rem_cond),
    .i_value (IPG_RW'(REMIND_CYCLES - 1)),
    .o_done  (rem_done)
  );

  // pulse start: from idle, or straight out of an expired gap
  assign start = pend & mode_ok &
                 ((state == IPG_IDLE) || (state == IPG_GAP && tmr_done));

  // pending trigger; absorbed while low, held through the gap
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      pend <= 1'b0;
    end else if (!mode_ok) begin
      pend <= 1'b0;
    end else if (start || state == IPG_LOW) begin
      pend <= 1'b0;
    end else if (trig) begin
      pend <= 1'b1;
    end
  end

  // one timer shared by the low time and the gap
  assign tmr_ld = start | ((state == IPG_LOW) & (tmr_done | ~mode_ok));

  ipg_timer #(.W(IPG_PW)) u_pulse (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_load  (tmr_ld),
    .i_value (start ? IPG_PW'(PULSE_CYCLES - 1)
                    : IPG_PW'(GAP_CYCLES - 1)),
    .o_done  (tmr_done)
  );

  // pulse state machine and pin level
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state      <= IPG_IDLE;
      o_intn_out <= 1'b1;
    end else begin
      unique case (state)
        IPG_IDLE: begin
          if (start) begin
            state      <= IPG_LOW;
            o_intn_out <= 1'b0;
          end
        end
        IPG_LOW: begin
          if (!mode_ok || tmr_done) begin
            state      <= IPG_GAP;
            o_intn_out <= 1'b1;
          end
        end
        IPG_GAP: begin
          if (start) begin
            state      <= IPG_LOW;
            o_intn_out <= 1'b0;
          end else if (tmr_done) begin
            state <= IPG_IDLE;
          end
        end
      endcase
    end
  end

  // pin released as input during init
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_intn_oe_n <= 1'b1;
    end else begin
      o_intn_oe_n <= (mode_q == IPG_INIT);
    end
  end

  // init-mode pin filter for debug bring-up entry
  assign filt_ld = !((mode_q == IPG_INIT) && !i_intn_pin);

  ipg_timer #(.W(IPG_FW)) u_filter (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_load  (filt_ld),
    .i_value (IPG_FW'(FILT_CYCLES - 1)),
    .o_done  (filt_done)
  );

  // debug entry stays until reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_debug_bringup <= 1'b0;
    end else if (filt_done && !filt_ld) begin
      o_debug_bringup <= 1'b1;
    end
  end

  // wake-up request in low-power modes
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_wake_request <= 1'b0;
    end else begin
      o_wake_request <= ipg_wake_mode(mode_q) &
        ((i_wake_edge & cfg_reg[IPG_CFG_PIN]) |
         (i_timer_wake & cfg_reg[IPG_CFG_TIMER]));
    end
  end

  // register read port, data in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_addr)
        IPG_OFS_MASK:  o_rdata <= interrupt_mask_reg;
        IPG_OFS_CFG:   o_rdata <= cfg_reg;
        IPG_OFS_SUP:   o_rdata <= supply_view;
        IPG_OFS_THERM: o_rdata <= thermal_view;
        IPG_OFS_DRAIN: o_rdata <= drain_view;
        IPG_OFS_DEV:   o_rdata <= device_view;
        IPG_OFS_WAKE:  o_rdata <= wake_view;
        IPG_OFS_INFO:  o_rdata <= {5'h00, pend, state == IPG_LOW,
                                   o_debug_bringup};
        default:       o_rdata <= 8'h00;
      endcase
    end
  end

  // helper counters of low and high time for the checks
  int unsigned low_len;
  int unsigned high_len;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      low_len  <= 0;
      high_len <= GAP_CYCLES;
    end else begin
      low_len  <= o_intn_out ? 0 : low_len + 1;
      high_len <= !o_intn_out ? 0 :
                  (high_len < GAP_CYCLES ? high_len + 1 : high_len);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  property p_pulse_width;
    $rose(o_intn_out) && $past(mode_ok) |-> low_len == PULSE_CYCLES;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("pulse width wrong");

  property p_min_gap;
    $fell(o_intn_out) |-> high_len == GAP_CYCLES;
  endproperty
  a_min_gap: assert property (p_min_gap)
    else $error("gap too short");

  property p_mode_gate;
    $fell(o_intn_out) |-> $past(mode_ok);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("pulse in forbidden mode");

  property p_single;
    state == IPG_LOW && mode_ok && !tmr_done |=> !o_intn_out;
  endproperty
  a_single: assert property (p_single)
    else $error("pin toggled while low");

  property p_gap_hold;
    state == IPG_GAP && trig && !start |=> pend;
  endproperty
  a_gap_hold: assert property (p_gap_hold)
    else $error("trigger lost in gap");

  property p_latch;
    (($past(supply_status_reg) & ~$past(sup_clr)) &
     ~supply_status_reg) == 8'h00;
  endproperty
  a_latch: assert property (p_latch)
    else $error("status bit dropped");

  property p_refresh;
    $fell(o_intn_out) |-> device_view == $past(device_status_reg);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("view not refreshed");

  property p_cyc_off;
    !cfg_reg[IPG_CFG_CYC] && !(|grp_new) && !(|wake_new) &&
      !stop_entry && !init_exit_wake |-> !trig;
  endproperty
  a_cyc_off: assert property (p_cyc_off)
    else $error("reminder while disabled");

  property p_remind_src;
    rem_trig |-> |(device_status_reg & IPG_DEV_SERIAL);
  endproperty
  a_remind_src: assert property (p_remind_src)
    else $error("reminder without serial fail");

  property p_stop_entry;
    stop_entry && (|wake_status_reg) && state == IPG_IDLE
      |=> pend || !o_intn_out;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("no pulse on stop entry");

  c_pulse:  cover property ($rose(o_intn_out));
  c_remind: cover property (rem_trig && state == IPG_IDLE);
  c_stop:   cover property (stop_entry && trig);
  c_debug:  cover property ($rose(o_debug_bringup));

endmodule : ipg_interrupt_pulse_generator

// *** ipg_pkg.sv ***
/*
  Shared constants, types and decode helpers for the interrupt pulse
  generator. Assumes a single 125 MHz clock domain and an 8-bit register
  port with a 4-bit word address.
*/
package ipg_pkg;

  // clock and timing figures in their own units
  localparam int unsigned IPG_CLK_PERIOD_NS = 8;
  localparam int unsigned IPG_PULSE_US      = 100;
  localparam int unsigned IPG_GAP_US        = 100;
  localparam int unsigned IPG_REMIND_MS     = 5;
  localparam int unsigned IPG_FILT_US       = 64;

  // derived cycle counts, rounded up to whole cycles
  localparam int unsigned IPG_PULSE_CYC =
    (IPG_PULSE_US * 1000 + IPG_CLK_PERIOD_NS - 1) / IPG_CLK_PERIOD_NS;
  localparam int unsigned IPG_GAP_CYC =
    (IPG_GAP_US * 1000 + IPG_CLK_PERIOD_NS - 1) / IPG_CLK_PERIOD_NS;
  localparam int unsigned IPG_REMIND_CYC =
    (IPG_REMIND_MS * 1000000 + IPG_CLK_PERIOD_NS - 1) / IPG_CLK_PERIOD_NS;
  localparam int unsigned IPG_FILT_CYC =
    (IPG_FILT_US * 1000 + IPG_CLK_PERIOD_NS - 1) / IPG_CLK_PERIOD_NS;

  // bus and counter widths
  localparam int unsigned IPG_AW = 4;
  localparam int unsigned IPG_DW = 8;
  localparam int unsigned IPG_PW = 14;
  localparam int unsigned IPG_RW = 20;
  localparam int unsigned IPG_FW = 13;

  // register word addresses
  localparam logic [3:0] IPG_OFS_MASK  = 4'h0;
  localparam logic [3:0] IPG_OFS_CFG   = 4'h1;
  localparam logic [3:0] IPG_OFS_SUP   = 4'h2;
  localparam logic [3:0] IPG_OFS_THERM = 4'h3;
  localparam logic [3:0] IPG_OFS_DRAIN = 4'h4;
  localparam logic [3:0] IPG_OFS_DEV   = 4'h5;
  localparam logic [3:0] IPG_OFS_WAKE  = 4'h6;
  localparam logic [3:0] IPG_OFS_INFO  = 4'h7;

  // group positions in the mask register
  localparam int unsigned IPG_GRP_SUPPLY  = 0;
  localparam int unsigned IPG_GRP_THERMAL = 1;
  localparam int unsigned IPG_GRP_BRIDGE  = 2;
  localparam int unsigned IPG_GRP_SERIAL  = 3;

  // configuration bits
  localparam int unsigned IPG_CFG_PIN   = 0;
  localparam int unsigned IPG_CFG_TIMER = 1;
  localparam int unsigned IPG_CFG_BRAKE = 2;
  localparam int unsigned IPG_CFG_CYC   = 3;

  // wake status bit positions
  localparam int unsigned IPG_WAKE_PIN   = 0;
  localparam int unsigned IPG_WAKE_TIMER = 1;
  localparam int unsigned IPG_WAKE_BRAKE = 2;

  // field masks
  localparam logic [7:0] IPG_SUP_NOINT   = 8'h0F;
  localparam logic [7:0] IPG_THERM_NOINT = 8'h80;
  localparam logic [7:0] IPG_BRAKE_BITS  = 8'h07;
  localparam logic [7:0] IPG_DEV_SERIAL  = 8'h03;
  localparam logic [7:0] IPG_WAKE_SRC    = 8'h07;

  // values after reset
  localparam logic [7:0] IPG_MASK_RST = 8'h00;
  localparam logic [7:0] IPG_CFG_RST  = 8'h08;

  typedef enum logic [2:0] {
    IPG_INIT, IPG_NORMAL, IPG_STOP, IPG_SLEEP, IPG_RESTART, IPG_FAILSAFE
  } ipg_mode_e;

  typedef enum logic [1:0] {IPG_IDLE, IPG_LOW, IPG_GAP} ipg_state_e;

  // modes in which the pin may pulse
  function automatic logic ipg_irq_mode_ok(input ipg_mode_e m);
    return (m == IPG_NORMAL) || (m == IPG_STOP);
  endfunction : ipg_irq_mode_ok

  // modes in which a wake event wakes the device
  function automatic logic ipg_wake_mode(input ipg_mode_e m);
    return (m == IPG_SLEEP) || (m == IPG_FAILSAFE);
  endfunction : ipg_wake_mode

endpackage : ipg_pkg

// *** ipg_timer.sv ***
/*
  Loadable down-counter used for pulse, gap, reminder and filter timing.
  Assumes a synchronous active-low reset; counts once per clock.
*/
`timescale 1ns/1ns
module ipg_timer #(
  parameter int unsigned W = 8
) (
  input  logic         i_clock,
  input  logic         i_rst_b,
  input  logic         i_load,
  input  logic [W-1:0] i_value,
  output logic         o_done
);

  logic [W-1:0] count;

  // reset to all ones; without a load it still counts down, so done rises after 2^W-1 cycles
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      count <= '1;
    end else if (i_load) begin
      count <= i_value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign o_done = (count == '0);

endmodule : ipg_timer

// *** ipg_host_model.sv ***
/*
  Host side of the interrupt line: counts pulses, times the low and high
  phases, and pulls the pin low on request while the device does not drive.
  Assumes a pull-up holds the line high when nobody drives it.
*/
`timescale 1ns/1ns
module ipg_host_model (
  input  wire logic        i_clock,
  input  wire logic        i_out,
  input  wire logic        i_oe_n,
  input  wire logic        i_pull_low,
  output logic             o_pin,
  output logic [15:0]      o_count,
  output logic [15:0]      o_low_w,
  output logic [15:0]      o_gap_w
);
  logic        lvl_q   = 1'b1;
  logic [15:0] run     = 16'h0000;
  logic [15:0] count_q = 16'h0000;
  logic [15:0] low_q   = 16'h0000;
  logic [15:0] gap_q   = 16'h0000;
  // wire level: device drive, else host pull or pull-up
  assign o_pin   = i_oe_n ? ~i_pull_low : i_out;
  assign o_count = count_q;
  assign o_low_w = low_q;
  assign o_gap_w = gap_q;
  // time each phase of the level that the device drives
  always @(posedge i_clock) begin
    lvl_q <= i_oe_n | i_out;
    if ((i_oe_n | i_out) != lvl_q) begin
      run <= 16'h0001;
      if (lvl_q) begin
        count_q <= count_q + 16'h0001;
        gap_q   <= run;
      end else begin
        low_q <= run;
      end
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule : ipg_host_model

// *** tb_interrupt_pulse_generator.sv ***
/*
  Self-checking bench for the interrupt pulse generator: register tasks,
  event pulses and a host model on the pin. Assumes shortened timing
  parameters (pulse 20, gap 20, reminder 200, filter 16 cycles).
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_interrupt_pulse_generator;
  import ipg_pkg::*;
  logic        i_clock, i_rst_b, i_wake_edge, i_wake_level, i_timer_wake;
  logic        i_wr, i_rd, pull_low, i_intn_pin, seen;
  ipg_mode_e   i_mode;
  logic [7:0]  i_supply_evt, i_thermal_evt, i_drain_evt, i_device_evt;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic        o_intn_out, o_intn_oe_n, o_debug_bringup, o_wake_request;
  logic [15:0] cnt, low_w, gap_w, c0;
  int          n_fail = 0;
  int          cmp_count = 0;

  ipg_interrupt_pulse_generator #(.PULSE_CYCLES(20), .GAP_CYCLES(20),
    .REMIND_CYCLES(200), .FILT_CYCLES(16)) i_ipg_interrupt_pulse_generator (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_mode(i_mode),
    .i_supply_evt(i_supply_evt), .i_thermal_evt(i_thermal_evt),
    .i_drain_evt(i_drain_evt), .i_device_evt(i_device_evt),
    .i_wake_edge(i_wake_edge), .i_wake_level(i_wake_level),
    .i_timer_wake(i_timer_wake), .i_intn_pin(i_intn_pin),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_intn_out(o_intn_out), .o_intn_oe_n(o_intn_oe_n),
    .o_debug_bringup(o_debug_bringup), .o_wake_request(o_wake_request));

  ipg_host_model i_ipg_host_model (
    .i_clock(i_clock), .i_out(o_intn_out), .i_oe_n(o_intn_oe_n),
    .i_pull_low(pull_low), .o_pin(i_intn_pin), .o_count(cnt),
    .o_low_w(low_w), .o_gap_w(gap_w));

  // free-running clock, 8 ns period
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    tick(1);
    i_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input string nm);
    i_addr <= a;
    i_rd   <= 1'b1;
    tick(1);
    i_rd   <= 1'b0;
    #1 `CHK(nm, e, o_rdata)
  endtask : rd

  // clear every bit, then read back to confirm the event is gone
  task automatic clr(input logic [3:0] a, input string nm);
    wr(a, 8'hFF);
    rd(a, 8'h00, nm);
  endtask : clr

  task automatic ev(input logic [7:0] s, t, d, v);
    i_supply_evt  <= s;
    i_thermal_evt <= t;
    i_drain_evt   <= d;
    i_device_evt  <= v;
    tick(1);
    i_supply_evt  <= 8'h00;
    i_thermal_evt <= 8'h00;
    i_drain_evt   <= 8'h00;
    i_device_evt  <= 8'h00;
  endtask : ev

  // pulses seen since c0 after a fixed window
  task automatic expect_n(input int n, input logic [15:0] d,
                          input string nm);
    tick(n);
    `CHK(nm, c0 + d, cnt)
  endtask : expect_n

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // hang guard
  initial begin
    #80000;
    n_fail++;
    final_report();
  end

  // main sequence
  initial begin
    i_rst_b       <= 1'b0;
    i_mode        <= IPG_INIT;
    i_supply_evt  <= 8'h00;
    i_thermal_evt <= 8'h00;
    i_drain_evt   <= 8'h00;
    i_device_evt  <= 8'h00;
    i_wake_edge   <= 1'b0;
    i_wake_level  <= 1'b0;
    i_timer_wake  <= 1'b0;
    i_addr        <= 4'h0;
    i_wdata       <= 8'h00;
    i_wr          <= 1'b0;
    i_rd          <= 1'b0;
    pull_low      <= 1'b0;
    tick(4);
    i_rst_b <= 1'b1;
    tick(1);
    rd(IPG_OFS_MASK, 8'h00, "mask");
    rd(IPG_OFS_CFG, 8'h08, "cfg");
    rd(4'h9, 8'h00, "unmapped");
    // host holds the pin low in init to select bring-up
    pull_low <= 1'b1;
    for (int i = 0; i < 9000 && o_debug_bringup !== 1'b1; i++) tick(1);
    `CHK("debug", 1'b1, o_debug_bringup)
    `CHK("oe_init", 1'b1, o_intn_oe_n)
    rd(IPG_OFS_INFO, 8'h01, "info");
    if (n_fail > 0) final_report();
    pull_low <= 1'b0;
    // init to normal with the wake pin high
    c0 = cnt;
    i_wake_level <= 1'b1;
    i_mode       <= IPG_NORMAL;
    expect_n(40, 16'h0001, "init_exit");
    `CHK("low_w", 16'h0014, low_w)
    `CHK("oe_norm", 1'b0, o_intn_oe_n)
    rd(IPG_OFS_WAKE, 8'h01, "wake");
    i_wake_level <= 1'b0;
    clr(IPG_OFS_WAKE, "wake_clr");
    // masked group, then excluded fault bits
    wr(IPG_OFS_MASK, 8'h0E);
    c0 = cnt;
    ev(8'h10, 8'h00, 8'h00, 8'h00);
    expect_n(40, 16'h0000, "masked");
    clr(IPG_OFS_SUP, "sup_clr");
    wr(IPG_OFS_MASK, 8'h0F);
    c0 = cnt;
    ev(8'h0F, 8'h80, 8'h00, 8'h00);
    expect_n(40, 16'h0000, "excluded");
    clr(IPG_OFS_SUP, "sup_clr2");
    clr(IPG_OFS_THERM, "therm_clr");
    // supply group: one pulse, no reminder
    c0 = cnt;
    ev(8'h10, 8'h00, 8'h00, 8'h00);
    expect_n(300, 16'h0001, "supply");
    rd(IPG_OFS_SUP, 8'h10, "sup_view");
    clr(IPG_OFS_SUP, "sup_clr3");
    // simultaneous events, then a trigger inside the gap
    c0 = cnt;
    ev(8'h00, 8'h01, 8'h01, 8'h00);
    tick(24);
    wr(IPG_OFS_THERM, 8'hFF);
    ev(8'h00, 8'h02, 8'h00, 8'h00);
    `CHK("simult", c0 + 16'h0001, cnt)
    expect_n(60, 16'h0002, "gap_trig");
    `CHK("gap", 1'b1, gap_w >= 16'h0014 && gap_w <= 16'h0018)
    clr(IPG_OFS_THERM, "therm_clr2");
    clr(IPG_OFS_DRAIN, "drain_clr");
    // checksum failure repeats until periodic enable drops
    c0 = cnt;
    ev(8'h00, 8'h00, 8'h00, 8'h02);
    expect_n(230, 16'h0002, "remind");
    wr(IPG_OFS_CFG, 8'h00);
    c0 = cnt;
    expect_n(450, 16'h0000, "cyc_off");
    rd(IPG_OFS_DEV, 8'h02, "dev_held");
    clr(IPG_OFS_DEV, "dev_clr");
    // timer wake source beside the group masks
    wr(IPG_OFS_CFG, 8'h03);
    c0 = cnt;
    i_timer_wake <= 1'b1;
    tick(1);
    i_timer_wake <= 1'b0;
    expect_n(40, 16'h0001, "timer");
    clr(IPG_OFS_WAKE, "wake_clr2");
    // sleep: wake request, no pulse; stop entry with wake bit set
    i_mode <= IPG_SLEEP;
    tick(2);
    c0 = cnt;
    seen = 1'b0;
    i_wake_edge <= 1'b1;
    tick(1);
    i_wake_edge <= 1'b0;
    repeat (4) begin
      #1 if (o_wake_request === 1'b1) seen = 1'b1;
      @(posedge i_clock);
    end
    `CHK("wake_req", 1'b1, seen)
    expect_n(40, 16'h0000, "sleep_quiet");
    i_mode <= IPG_STOP;
    expect_n(40, 16'h0001, "stop_entry");
    clr(IPG_OFS_WAKE, "wake_clr3");
    // wake pin edge in normal mode
    i_mode <= IPG_NORMAL;
    tick(2);
    c0 = cnt;
    i_wake_edge <= 1'b1;
    tick(1);
    i_wake_edge <= 1'b0;
    expect_n(40, 16'h0001, "wk_normal");
    final_report();
  end
endmodule : tb_interrupt_pulse_generator
